// >>> logic/dma_channel_options_and_request_routing.sv
// DMA channel option registers, address stepping and timer/logic-array request routing
// Notes on behaviour
// - Option registers map channel C to bit C over 30:0; bit 31 reads zero.
// - Writing one to a byte swap clear bit disables swapping; zeros change nothing.
// - Writing one to a byte swap set bit enables swapping; reads show state.
// - Source decrement makes the channel source address step down per access.
// - Source decrement set: ones enable, zeros no effect, reads show state.
// - Source decrement clear: ones restore increment, zeros change nothing.
// - Destination decrement makes the channel destination address step down per access.
// - Destination decrement set: ones enable, zeros no effect, reads show state.
// - Destination decrement clear: ones restore increment, zeros change nothing.
// - Revision register holds read-only 8-bit code in low byte, rest zero.
// - Bits 0 and 1 gate routed outputs 0 and 1; reset disabled.
// - Output 0 selector: 0-3 logic array, 4-6 short timers, 7-8 wide timers.
// - Output 1 selector uses the same encoding; codes 9 to 15 reserved.
// - Four bits enable logic-array requests 3 to 0; reset disabled.
// - Five bits enable timer requests, short 0-2 then wide 0-1; reset disabled.
// - Per-timer 2-bit trigger type: high, rising, low, falling.
`timescale 1ns/1ps
module dma_channel_options_and_request_routing #(
  parameter logic [7:0] REVISION = dma_opt_pkg::REV_DEFAULT
) (
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  input  wire logic                            cyc_i,
  input  wire logic                            stb_i,
  input  wire logic                            we_i,
  input  wire logic [31:0]                     adr_i,
  input  wire logic [3:0]                      sel_i,
  input  wire logic [31:0]                     dat_i,
  output logic      [31:0]                     dat_o,
  output logic                                 ack_o,
  output logic                                 err_o,
  input  wire logic [dma_opt_pkg::PLA_N-1:0]   logicArrayReq,
  input  wire logic [dma_opt_pkg::TMR_N-1:0]   timerReq,
  output logic      [1:0]                      routedReq,
  output logic      [dma_opt_pkg::CH_N-1:0]    byteSwapEn,
  output logic      [dma_opt_pkg::CH_N-1:0]    srcDecEn,
  output logic      [dma_opt_pkg::CH_N-1:0]    dstDecEn,
  input  wire logic                            stepValid,
  input  wire logic [4:0]                      stepChan,
  input  wire logic [dma_opt_pkg::ADDR_W-1:0]  stepSize,
  input  wire logic [dma_opt_pkg::ADDR_W-1:0]  srcAddrIn,
  input  wire logic [dma_opt_pkg::ADDR_W-1:0]  dstAddrIn,
  output logic      [dma_opt_pkg::ADDR_W-1:0]  srcAddrOut,
  output logic      [dma_opt_pkg::ADDR_W-1:0]  dstAddrOut,
  output logic                                 stepDone
);

  typedef struct packed {
    logic                            ack;
    logic                            err;
    logic [31:0]                     rdat;
    logic [dma_opt_pkg::CH_N-1:0]    bswap;
    logic [dma_opt_pkg::CH_N-1:0]    srcDec;
    logic [dma_opt_pkg::CH_N-1:0]    dstDec;
    logic [1:0]                      outEn;
    logic [3:0]                      sel0;
    logic [3:0]                      sel1;
    logic [dma_opt_pkg::PLA_N-1:0]   plaEn;
    logic [dma_opt_pkg::TMR_N-1:0]   tmrEn;
    logic [dma_opt_pkg::TT_W-1:0]    ttype;
    logic [dma_opt_pkg::TMR_N-1:0]   tmrPrev;
    logic [1:0]                      routed;
    logic [dma_opt_pkg::ADDR_W-1:0]  srcAddr;
    logic [dma_opt_pkg::ADDR_W-1:0]  dstAddr;
    logic                            stepDone;
  } state_t;

  state_t                           state_r;
  state_t                           state_nxt;
  logic                             busReq;
  logic [31:0]                      laneMask;
  logic [31:0]                      wd;
  logic [31:0]                      adrW;
  logic [dma_opt_pkg::TMR_N-1:0]    tmrCond;
  logic [dma_opt_pkg::SRC_N-1:0]    srcVec;

  // One request per access; a new one is taken only after the answer is gone
  assign busReq = cyc_i && stb_i && !state_r.ack && !state_r.err;
  assign adrW   = {adr_i[31:2], 2'b00};
  assign laneMask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign wd     = dat_i & laneMask;

  // Trigger conditioning; edges use the previous sample, so they last one cycle
  always_comb
  begin
    for (int t = 0; t < dma_opt_pkg::TMR_N; t++)
    begin
      case (state_r.ttype[2*t +: 2])
        dma_opt_pkg::TT_HIGH: tmrCond[t] = timerReq[t];
        dma_opt_pkg::TT_RISE: tmrCond[t] = timerReq[t] && !state_r.tmrPrev[t];
        dma_opt_pkg::TT_LOW:  tmrCond[t] = !timerReq[t];
        dma_opt_pkg::TT_FALL: tmrCond[t] = !timerReq[t] && state_r.tmrPrev[t];
        default:              tmrCond[t] = 1'b0;
      endcase
    end
  end

  // Index of a source equals its selector code
  assign srcVec = {tmrCond & state_r.tmrEn, logicArrayReq & state_r.plaEn};

  always_comb
  begin
    logic hit;
    logic [31:0] rd;
    logic [31:0] srcDecW;
    logic [31:0] dstDecW;
    hit = 1'b0;
    rd = 32'h00000000;
    srcDecW = {1'b0, state_r.srcDec};
    dstDecW = {1'b0, state_r.dstDec};
    state_nxt = state_r;
    state_nxt.ack = 1'b0;
    state_nxt.err = 1'b0;
    state_nxt.stepDone = 1'b0;
    state_nxt.tmrPrev = timerReq;
    if (busReq)
    begin
      hit = 1'b1;
      case (adrW)
        dma_opt_pkg::OFS_BSWAP_SET:
        begin
          rd = {1'b0, state_r.bswap};
          if (we_i)
            state_nxt.bswap = state_r.bswap | wd[30:0];
        end
        dma_opt_pkg::OFS_BSWAP_CLR:
        begin
          if (we_i)
            state_nxt.bswap = state_r.bswap & ~wd[30:0];
        end
        dma_opt_pkg::OFS_SRCDEC_SET:
        begin
          rd = {1'b0, state_r.srcDec};
          if (we_i)
            state_nxt.srcDec = state_r.srcDec | wd[30:0];
        end
        dma_opt_pkg::OFS_SRCDEC_CLR:
        begin
          if (we_i)
            state_nxt.srcDec = state_r.srcDec & ~wd[30:0];
        end
        dma_opt_pkg::OFS_DSTDEC_SET:
        begin
          rd = {1'b0, state_r.dstDec};
          if (we_i)
            state_nxt.dstDec = state_r.dstDec | wd[30:0];
        end
        dma_opt_pkg::OFS_DSTDEC_CLR:
        begin
          if (we_i)
            state_nxt.dstDec = state_r.dstDec & ~wd[30:0];
        end
        dma_opt_pkg::OFS_REVISION:
          rd = {24'h000000, REVISION};
        dma_opt_pkg::OFS_OUT_EN:
        begin
          rd = {30'h00000000, state_r.outEn};
          if (we_i)
            state_nxt.outEn = wd[1:0];
        end
        dma_opt_pkg::OFS_SEL0:
        begin
          rd = {28'h0000000, state_r.sel0};
          if (we_i)
            state_nxt.sel0 = wd[3:0];
        end
        dma_opt_pkg::OFS_SEL1:
        begin
          rd = {28'h0000000, state_r.sel1};
          if (we_i)
            state_nxt.sel1 = wd[3:0];
        end
        dma_opt_pkg::OFS_PLA_EN:
        begin
          rd = {28'h0000000, state_r.plaEn};
          if (we_i)
            state_nxt.plaEn = wd[3:0];
        end
        dma_opt_pkg::OFS_TMR_EN:
        begin
          rd = {27'h0000000, state_r.tmrEn};
          if (we_i)
            state_nxt.tmrEn = wd[4:0];
        end
        dma_opt_pkg::OFS_TTYPE:
        begin
          rd = {22'h000000, state_r.ttype};
          if (we_i)
            state_nxt.ttype = wd[9:0];
        end
        default:
          hit = 1'b0;
      endcase
      state_nxt.ack = hit;
      state_nxt.err = !hit;
      state_nxt.rdat = rd;
    end
    // Reserved codes pick no source rather than aliasing onto a real one
    state_nxt.routed[0] = state_r.outEn[dma_opt_pkg::OUT0_EN_BIT]
                          && (state_r.sel0 <= dma_opt_pkg::SRC_WIDE1)
                          && srcVec[state_r.sel0];
    state_nxt.routed[1] = state_r.outEn[dma_opt_pkg::OUT1_EN_BIT]
                          && (state_r.sel1 <= dma_opt_pkg::SRC_WIDE1)
                          && srcVec[state_r.sel1];
    // Channel 31 does not exist and always increments
    if (stepValid)
    begin
      state_nxt.stepDone = 1'b1;
      if (srcDecW[stepChan])
        state_nxt.srcAddr = srcAddrIn - stepSize;
      else
        state_nxt.srcAddr = srcAddrIn + stepSize;
      if (dstDecW[stepChan])
        state_nxt.dstAddr = dstAddrIn - stepSize;
      else
        state_nxt.dstAddr = dstAddrIn + stepSize;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= '0;
    else
      state_r <= state_nxt;
  end

  assign dat_o      = state_r.rdat;
  assign ack_o      = state_r.ack;
  assign err_o      = state_r.err;
  assign routedReq  = state_r.routed;
  assign byteSwapEn = state_r.bswap;
  assign srcDecEn   = state_r.srcDec;
  assign dstDecEn   = state_r.dstDec;
  assign srcAddrOut = state_r.srcAddr;
  assign dstAddrOut = state_r.dstAddr;
  assign stepDone   = state_r.stepDone;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic fullWr;
  assign fullWr = busReq && we_i && (sel_i == 4'hf);

  property p_bswap_clr;
    fullWr && (adrW == dma_opt_pkg::OFS_BSWAP_CLR)
    |=> ((byteSwapEn & $past(dat_i[30:0])) == 31'h0)
        && ((byteSwapEn & ~$past(dat_i[30:0])) == ($past(byteSwapEn) & ~$past(dat_i[30:0])));
  endproperty
  a_bswap_clr: assert property (p_bswap_clr) else $error("byte swap clear wrong");

  property p_bswap_set;
    fullWr && (adrW == dma_opt_pkg::OFS_BSWAP_SET)
    |=> (byteSwapEn == ($past(byteSwapEn) | $past(dat_i[30:0])));
  endproperty
  a_bswap_set: assert property (p_bswap_set) else $error("byte swap set wrong");

  property p_src_set;
    fullWr && (adrW == dma_opt_pkg::OFS_SRCDEC_SET)
    |=> (srcDecEn == ($past(srcDecEn) | $past(dat_i[30:0])));
  endproperty
  a_src_set: assert property (p_src_set) else $error("source decrement set wrong");

  property p_src_clr;
    fullWr && (adrW == dma_opt_pkg::OFS_SRCDEC_CLR)
    |=> (srcDecEn == ($past(srcDecEn) & ~$past(dat_i[30:0])));
  endproperty
  a_src_clr: assert property (p_src_clr) else $error("source decrement clear wrong");

  property p_dst_set;
    fullWr && (adrW == dma_opt_pkg::OFS_DSTDEC_SET)
    |=> (dstDecEn == ($past(dstDecEn) | $past(dat_i[30:0])));
  endproperty
  a_dst_set: assert property (p_dst_set) else $error("dest decrement set wrong");

  property p_dst_clr;
    fullWr && (adrW == dma_opt_pkg::OFS_DSTDEC_CLR)
    |=> (dstDecEn == ($past(dstDecEn) & ~$past(dat_i[30:0])));
  endproperty
  a_dst_clr: assert property (p_dst_clr) else $error("dest decrement clear wrong");

  property p_rsv_bit;
    busReq && !we_i && (adrW == dma_opt_pkg::OFS_SRCDEC_SET)
    |=> ack_o && !dat_o[dma_opt_pkg::RSV_CH_BIT] && (dat_o[30:0] == $past(srcDecEn));
  endproperty
  a_rsv_bit: assert property (p_rsv_bit) else $error("channel read wrong");

  property p_wo_read;
    busReq && !we_i && (adrW == dma_opt_pkg::OFS_BSWAP_CLR)
    |=> ack_o && (dat_o == 32'h00000000);
  endproperty
  a_wo_read: assert property (p_wo_read) else $error("write-only register read not zero");

  property p_revision;
    busReq && !we_i && (adrW == dma_opt_pkg::OFS_REVISION) |=> ack_o && (dat_o == {24'h0, REVISION});
  endproperty
  a_revision: assert property (p_revision) else $error("revision read wrong");

  property p_out_gate;
    !state_r.outEn[0] |=> !routedReq[0];
  endproperty
  a_out_gate: assert property (p_out_gate) else $error("routed output 0 not gated");

  property p_route0;
    routedReq[0] |-> $past(state_r.sel0) <= dma_opt_pkg::SRC_WIDE1 && $past(state_r.outEn[0])
      && (($past(state_r.sel0) < dma_opt_pkg::SRC_SHORT0) ? $past(state_r.plaEn[state_r.sel0[1:0]])
          : $past(state_r.tmrEn[3'(state_r.sel0 - dma_opt_pkg::SRC_SHORT0)]));
  endproperty
  a_route0: assert property (p_route0) else $error("routed request 0 without enabled source");

  property p_route1_pla;
    state_r.outEn[1] && (state_r.sel1 == dma_opt_pkg::SRC_PLA0) && state_r.plaEn[0] && logicArrayReq[0]
    |=> routedReq[1];
  endproperty
  a_route1_pla: assert property (p_route1_pla) else $error("routed request 1 missed source");

  property p_sel_rsv;
    state_r.sel1 > dma_opt_pkg::SRC_WIDE1 |=> !routedReq[1];
  endproperty
  a_sel_rsv: assert property (p_sel_rsv) else $error("reserved selector routed a source");

  property p_rise;
    state_r.outEn[0] && (state_r.sel0 == dma_opt_pkg::SRC_SHORT0) && state_r.tmrEn[0]
      && (state_r.ttype[1:0] == dma_opt_pkg::TT_RISE) && timerReq[0] && $past(timerReq[0])
    |=> !routedReq[0];
  endproperty
  a_rise: assert property (p_rise) else $error("rising trigger fired on steady level");

  property p_fall;
    state_r.outEn[0] && (state_r.sel0 == dma_opt_pkg::SRC_SHORT0) && state_r.tmrEn[0]
      && (state_r.ttype[1:0] == dma_opt_pkg::TT_FALL) && !timerReq[0] && $past(timerReq[0])
    |=> routedReq[0];
  endproperty
  a_fall: assert property (p_fall) else $error("falling trigger missed");

  property p_step;
    stepValid && (stepChan < 5'd31)
    |=> stepDone
        && (srcAddrOut == ($past(srcDecEn[stepChan]) ? $past(srcAddrIn) - $past(stepSize)
                                                     : $past(srcAddrIn) + $past(stepSize)))
        && (dstAddrOut == ($past(dstDecEn[stepChan]) ? $past(dstAddrIn) - $past(stepSize)
                                                     : $past(dstAddrIn) + $past(stepSize)));
  endproperty
  a_step: assert property (p_step) else $error("address step direction wrong");

endmodule : dma_channel_options_and_request_routing

// >>> shared/dma_opt_pkg.sv
// Register map, field layout and encodings of the DMA channel option and request routing block
package dma_opt_pkg;
  localparam int          CH_N           = 31;
  localparam int          ADDR_W         = 32;
  localparam int          TMR_N          = 5;
  localparam int          PLA_N          = 4;
  localparam int          SRC_N          = 9;
  localparam int          TT_W           = 2 * TMR_N;
  // Channel option registers
  localparam logic [31:0] OFS_BSWAP_SET  = 32'h40040800;
  localparam logic [31:0] OFS_BSWAP_CLR  = 32'h40040804;
  localparam logic [31:0] OFS_SRCDEC_SET = 32'h40040810;
  localparam logic [31:0] OFS_SRCDEC_CLR = 32'h40040814;
  localparam logic [31:0] OFS_DSTDEC_SET = 32'h40040818;
  localparam logic [31:0] OFS_DSTDEC_CLR = 32'h4004081c;
  localparam logic [31:0] OFS_REVISION   = 32'h40040fe0;
  // Request routing registers
  localparam logic [31:0] OFS_OUT_EN     = 32'h40007000;
  localparam logic [31:0] OFS_SEL0       = 32'h40007004;
  localparam logic [31:0] OFS_SEL1       = 32'h40007008;
  localparam logic [31:0] OFS_PLA_EN     = 32'h4000700c;
  localparam logic [31:0] OFS_TMR_EN     = 32'h40007010;
  localparam logic [31:0] OFS_TTYPE      = 32'h40007014;
  // Field positions
  localparam int          OUT0_EN_BIT    = 0;
  localparam int          OUT1_EN_BIT    = 1;
  localparam int          RSV_CH_BIT     = 31;
  // Reset values
  localparam logic [30:0] CH_RST         = 31'h00000000;
  localparam logic [1:0]  OUT_EN_RST     = 2'h0;
  localparam logic [3:0]  SEL_RST        = 4'h0;
  localparam logic [3:0]  PLA_EN_RST     = 4'h0;
  localparam logic [4:0]  TMR_EN_RST     = 5'h00;
  localparam logic [9:0]  TTYPE_RST      = 10'h000;
  // Arbitrary revision value
  localparam logic [7:0]  REV_DEFAULT    = 8'h5a;
  // Source codes of the routing selectors
  localparam logic [3:0]  SRC_PLA0       = 4'h0;
  localparam logic [3:0]  SRC_SHORT0     = 4'h4;
  localparam logic [3:0]  SRC_WIDE1      = 4'h8;
  // Trigger types
  localparam logic [1:0]  TT_HIGH        = 2'h0;
  localparam logic [1:0]  TT_RISE        = 2'h1;
  localparam logic [1:0]  TT_LOW         = 2'h2;
  localparam logic [1:0]  TT_FALL        = 2'h3;
endpackage : dma_opt_pkg

// >>> bench/req_source_model.sv
// Model of the logic-array and timer request sources on the far side
`timescale 1ns/1ps
module req_source_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [8:0] want,
  output logic      [3:0] logicArrayReq,
  output logic      [4:0] timerReq
);
  // Registered so the sources move just after an edge, as real peripheral flops do
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {timerReq, logicArrayReq} <= 9'h000;
    end
    else
    begin
      {timerReq, logicArrayReq} <= want;
    end
  end
endmodule : req_source_model

// >>> bench/dma_channel_options_and_request_routing_tb_top.sv
// Self-checking testbench of the DMA option and request routing block
`timescale 1ns/1ps
module dma_channel_options_and_request_routing_tb_top;
  logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [31:0] adr = 32'h0, datW = 32'h0, datR, stepA, stepB, stepS;
  logic [31:0] stepSize = 32'h0, srcIn = 32'h0, dstIn = 32'h0, srcOut, dstOut;
  logic [3:0]  sel = 4'hf, laReq;
  logic [4:0]  tmReq, stepChan = 5'h00;
  logic [1:0]  routedReq;
  logic [30:0] bsEn, srcEn, dstEn;
  logic [30:0] optM [3];
  logic [8:0]  want = 9'h000;
  logic        ack, err, stepValid = 1'b0, stepDone;
  logic [33:0] expQ [$];
  logic [33:0] expEntry;
  logic [31:0] setOfs [3] = '{32'h40040800, 32'h40040810, 32'h40040818};
  logic [31:0] clrOfs [3] = '{32'h40040804, 32'h40040814, 32'h4004081c};
  integer      seed = 32'h622f;
  int          fails = 0, total_checks = 0, cycles = 0, ch;
  logic [31:0] r, m;

  always #25 clk = ~clk;

  dma_channel_options_and_request_routing dut (
    .clk(clk), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(datW), .dat_o(datR), .ack_o(ack), .err_o(err),
    .logicArrayReq(laReq), .timerReq(tmReq), .routedReq(routedReq),
    .byteSwapEn(bsEn), .srcDecEn(srcEn), .dstDecEn(dstEn), .stepValid(stepValid),
    .stepChan(stepChan), .stepSize(stepSize), .srcAddrIn(srcIn), .dstAddrIn(dstIn),
    .srcAddrOut(srcOut), .dstAddrOut(dstOut), .stepDone(stepDone)
  );

  req_source_model partner (
    .clk(clk), .rst_n(rst_n), .want(want), .logicArrayReq(laReq), .timerReq(tmReq)
  );

  task summarize();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Entry layout: compare data, error expected, data
  task wb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [33:0] e);
    expQ.push_back(e);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datW <= d;
    sel <= r[3:0] | 4'hf;
    do
    begin
      @(posedge clk);
    end
    while (!(ack === 1'b1 || err === 1'b1));
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb

  task wr(input logic [31:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 34'h0);
  endtask : wr

  task rd(input logic [31:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, {2'b10, exp});
  endtask : rd

  // Sources and config settle through two register stages before routedReq shows them
  task route(input logic [1:0] exp);
    repeat (3) @(posedge clk);
    check({30'h0, routedReq}, {30'h0, exp});
  endtask : route

  always @(posedge clk)
  begin
    if (ack === 1'b1 || err === 1'b1)
    begin
      if (expQ.size() == 0)
        check(32'h1, 32'h0);
      else
      begin
        expEntry = expQ.pop_front();
        check({31'h0, err}, {31'h0, expEntry[32]});
        if (expEntry[33])
          check(datR, expEntry[31:0]);
      end
    end
  end

  // Ceiling well above the fewer than eight hundred cycles the sequence needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      fails++;
      summarize();
    end
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check({1'b0, bsEn | srcEn | dstEn}, 32'h0);
    for (int i = 0; i < 6; i++)
      rd(32'h40007000 + 32'(4 * i), 32'h0);
    rd(dma_opt_pkg::OFS_REVISION, {24'h0, dma_opt_pkg::REV_DEFAULT});
    wr(dma_opt_pkg::OFS_REVISION, 32'hffffffff);
    rd(dma_opt_pkg::OFS_REVISION, {24'h0, dma_opt_pkg::REV_DEFAULT});
    wb(1'b0, 32'h40040900, 32'h0, {2'b01, 32'h0});
    $display("test reset_and_map done");
    for (int k = 0; k < 3; k++)
    begin
      r = $random(seed);
      m = $random(seed);
      wr(setOfs[k], r | 32'h80000000);
      rd(setOfs[k], {1'b0, r[30:0]});
      wr(setOfs[k], 32'h0);
      wr(clrOfs[k], m);
      rd(clrOfs[k], 32'h0);
      optM[k] = r[30:0] & ~m[30:0];
      rd(setOfs[k], {1'b0, optM[k]});
      check({1'b0, k == 0 ? bsEn : k == 1 ? srcEn : dstEn}, {1'b0, optM[k]});
    end
    $display("test set_clear done");
    for (int i = 0; i < 8; i++)
    begin
      ch = {$random(seed)} % 31;
      stepA = $random(seed);
      stepB = $random(seed);
      stepS = {28'h0, 4'(1 << (i % 3))};
      stepChan <= ch[4:0];
      stepSize <= stepS;
      srcIn <= stepA;
      dstIn <= stepB;
      stepValid <= 1'b1;
      @(posedge clk);
      stepValid <= 1'b0;
      @(posedge clk);
      check({31'h0, stepDone}, 32'h1);
      check(srcOut, optM[1][ch] ? stepA - stepS : stepA + stepS);
      check(dstOut, optM[2][ch] ? stepB - stepS : stepB + stepS);
    end
    $display("test address_step done");
    wr(dma_opt_pkg::OFS_PLA_EN, 32'hf);
    wr(dma_opt_pkg::OFS_TMR_EN, 32'h1f);
    wr(dma_opt_pkg::OFS_OUT_EN, 32'h3);
    for (int c = 0; c < 16; c++)
    begin
      wr(dma_opt_pkg::OFS_SEL0, 32'(c));
      wr(dma_opt_pkg::OFS_SEL1, 32'(15 - c));
      rd(dma_opt_pkg::OFS_SEL1, 32'(15 - c));
      for (int s = 0; s < 9; s++)
      begin
        want <= 9'(1 << s);
        route({(15 - c) == s, c == s});
      end
    end
    wr(dma_opt_pkg::OFS_SEL0, 32'h0);
    wr(dma_opt_pkg::OFS_SEL1, 32'h0);
    want <= 9'h001;
    wr(dma_opt_pkg::OFS_PLA_EN, 32'he);
    route(2'b00);
    wr(dma_opt_pkg::OFS_PLA_EN, 32'hf);
    wr(dma_opt_pkg::OFS_OUT_EN, 32'h2);
    route(2'b10);
    wr(dma_opt_pkg::OFS_OUT_EN, 32'h3);
    wr(dma_opt_pkg::OFS_SEL0, {28'h0, dma_opt_pkg::SRC_SHORT0});
    want <= 9'h010;
    wr(dma_opt_pkg::OFS_TMR_EN, 32'h1e);
    route(2'b00);
    wr(dma_opt_pkg::OFS_TMR_EN, 32'h1f);
    wr(dma_opt_pkg::OFS_TTYPE, {30'h0, dma_opt_pkg::TT_LOW});
    want <= 9'h000;
    route(2'b01);
    wr(dma_opt_pkg::OFS_TTYPE, {30'h0, dma_opt_pkg::TT_RISE});
    want <= 9'h010;
    route(2'b01);
    route(2'b00);
    wr(dma_opt_pkg::OFS_TTYPE, {30'h0, dma_opt_pkg::TT_FALL});
    want <= 9'h000;
    route(2'b01);
    route(2'b00);
    $display("test routing done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check({1'b0, bsEn | srcEn | dstEn}, 32'h0);
    check({30'h0, routedReq}, 32'h0);
    for (int i = 0; i < 6; i++)
      rd(32'h40007000 + 32'(4 * i), 32'h0);
    $display("test mid_reset done");
    summarize();
  end
endmodule : dma_channel_options_and_request_routing_tb_top
